//--- common/acc_xfer_map.svh
// Purpose: opcodes, reset values and field positions for the accumulator load group
// Assumes: ten-bit instruction words, four-bit accumulator
// Notes: definitions only
`ifndef ACC_XFER_MAP_SVH
`define ACC_XFER_MAP_SVH

`define ACC_OP_ADC_CTRL_THREE 10'h246
`define ACC_OP_STACK_POINTER 10'h250
`define ACC_OP_IRQ_CTRL_ONE 10'h054
`define ACC_OP_IRQ_CTRL_TWO 10'h055
`define ACC_OP_TIMER_CTRL_ONE 10'h24B
`define ACC_OP_TIMER_CTRL_TWO 10'h24C
`define ACC_OP_TIMER_CTRL_THREE 10'h24D
`define ACC_OP_TIMER_CTRL_FOUR 10'h24E

`define ACC_RESET 4'h0
`define ACC_STACK_TOP_BIT 3
`define ACC_STACK_FILL 1'h0
`define ACC_SOURCE_COUNT 8

`endif

//--- common/acc_xfer_pkg.sv
// Purpose: types shared by the accumulator load group
// Assumes: nothing
// Notes: numbers live in acc_xfer_map.svh
package acc_xfer_pkg;

  typedef logic [3:0] nibble_t;
  typedef logic [9:0] opcode_t;

  typedef enum logic [3:0] {
    SRC_NONE = 4'h0,
    SRC_ADC_CTRL_THREE = 4'h1,
    SRC_STACK_POINTER = 4'h2,
    SRC_IRQ_CTRL_ONE = 4'h3,
    SRC_IRQ_CTRL_TWO = 4'h4,
    SRC_TIMER_CTRL_ONE = 4'h5,
    SRC_TIMER_CTRL_TWO = 4'h6,
    SRC_TIMER_CTRL_THREE = 4'h7,
    SRC_TIMER_CTRL_FOUR = 4'h8
  } src_e;

endpackage : acc_xfer_pkg

//--- rtl/acc_special_load.sv
// Purpose: executes the single-word loads of special registers into the accumulator
// Assumes: one instruction per core_clk edge with instr_valid high; sources are same-clock logic
// Notes: owns the accumulator; other instructions write it through other_acc_write
//
// What this block does
// RL1 - opcode 246 loads ADC control three
// RL2 - stack pointer to bits 2..0, bit3 zero
// RL3 - opcode 054 loads interrupt control one
// RL4 - opcode 055 loads interrupt control two
// RL5 - opcode 24B loads timer control one
// RL6 - opcode 24C loads timer control two
// RL7 - opcode 24D loads timer control three
// RL8 - opcode 24E loads timer control four
// RL9 - no carry change, no skip, source untouched
`timescale 1ns/10ps
`include "acc_xfer_map.svh"

module acc_special_load (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [9:0] opcode,
  input wire logic [3:0] adc_control_reg_three,
  input wire logic [2:0] stack_pointer,
  input wire logic [3:0] irq_control_reg_one,
  input wire logic [3:0] irq_control_reg_two,
  input wire logic [3:0] timer_control_reg_one,
  input wire logic [3:0] timer_control_reg_two,
  input wire logic [3:0] timer_control_reg_three,
  input wire logic [3:0] timer_control_reg_four,
  input wire logic other_acc_write,
  input wire logic [3:0] other_acc_data,
  output logic [3:0] acc_q,
  output logic load_done_q,
  output acc_xfer_pkg::src_e src_sel_q,
  output logic carry_write_q,
  output logic skip_q
);

  ////////////////////////////////////////////////////////////////////////////
  logic hit;
  acc_xfer_pkg::src_e sel;
  acc_xfer_pkg::nibble_t data;
  logic [3:0] acc_d;

  acc_src_decode u_decode (
    .instr_valid(instr_valid),
    .opcode(opcode),
    .adc_control_reg_three(adc_control_reg_three),
    .stack_pointer(stack_pointer),
    .irq_control_reg_one(irq_control_reg_one),
    .irq_control_reg_two(irq_control_reg_two),
    .timer_control_reg_one(timer_control_reg_one),
    .timer_control_reg_two(timer_control_reg_two),
    .timer_control_reg_three(timer_control_reg_three),
    .timer_control_reg_four(timer_control_reg_four),
    .hit(hit),
    .sel(sel),
    .data(data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // a load of the group wins over any other accumulator write in the same cycle
  always_comb begin
    if (hit) begin
      acc_d = data; // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8]
    end else if (other_acc_write) begin
      acc_d = other_acc_data;
    end else begin
      acc_d = acc_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= `ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_done_q <= 1'b0;
      src_sel_q <= acc_xfer_pkg::SRC_NONE;
    end else begin
      load_done_q <= hit;
      src_sel_q <= sel;
    end
  end

  // the group never writes carry and never asks for a skip
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      carry_write_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      carry_write_q <= 1'b0; // [RL9]
      skip_q <= 1'b0; // [RL9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_adc_three;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_ADC_CTRL_THREE
      |=> acc_q == $past(adc_control_reg_three) && load_done_q && src_sel_q == acc_xfer_pkg::SRC_ADC_CTRL_THREE;
  endproperty
  a_adc_three: assert property (p_adc_three) else $error("adc control three not loaded"); // [RL1]

  property p_stack_pointer;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_STACK_POINTER
      |=> acc_q[`ACC_STACK_TOP_BIT] == 1'b0 && acc_q[2:0] == $past(stack_pointer) && load_done_q;
  endproperty
  a_stack_pointer: assert property (p_stack_pointer) else $error("stack pointer load wrong"); // [RL2]

  property p_irq_one;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_IRQ_CTRL_ONE |=> acc_q == $past(irq_control_reg_one);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("interrupt control one not loaded"); // [RL3]

  property p_irq_two;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_IRQ_CTRL_TWO |=> acc_q == $past(irq_control_reg_two);
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("interrupt control two not loaded"); // [RL4]

  property p_timer_one;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_TIMER_CTRL_ONE
      |=> acc_q == $past(timer_control_reg_one) && src_sel_q == acc_xfer_pkg::SRC_TIMER_CTRL_ONE;
  endproperty
  a_timer_one: assert property (p_timer_one) else $error("timer control one not loaded"); // [RL5]

  property p_timer_two;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_TIMER_CTRL_TWO |=> acc_q == $past(timer_control_reg_two);
  endproperty
  a_timer_two: assert property (p_timer_two) else $error("timer control two not loaded"); // [RL6]

  property p_timer_three;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_TIMER_CTRL_THREE |=> acc_q == $past(timer_control_reg_three);
  endproperty
  a_timer_three: assert property (p_timer_three) else $error("timer control three not loaded"); // [RL7]

  property p_timer_four;
    @(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_TIMER_CTRL_FOUR |=> acc_q == $past(timer_control_reg_four);
  endproperty
  a_timer_four: assert property (p_timer_four) else $error("timer control four not loaded"); // [RL8]

  property p_no_side_effects;
    @(posedge core_clk) disable iff (rst)
    load_done_q |-> !carry_write_q && !skip_q;
  endproperty
  a_no_side_effects: assert property (p_no_side_effects) else $error("load touched carry or skip"); // [RL9]

  property p_hold_when_idle;
    @(posedge core_clk) disable iff (rst)
    !hit && !other_acc_write |=> $stable(acc_q) && !load_done_q;
  endproperty
  a_hold_when_idle: assert property (p_hold_when_idle) else $error("accumulator changed without a write");

  property p_one_cycle;
    @(posedge core_clk) disable iff (rst)
    load_done_q && !(instr_valid && hit) |=> !load_done_q;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("load lasted more than one cycle");

  c_stack_load: cover property (@(posedge core_clk) disable iff (rst)
    instr_valid && opcode == `ACC_OP_STACK_POINTER ##1 load_done_q);
  c_back_to_back: cover property (@(posedge core_clk) disable iff (rst) load_done_q [*2]);
  c_clash: cover property (@(posedge core_clk) disable iff (rst) hit && other_acc_write);
  c_timer_four: cover property (@(posedge core_clk) disable iff (rst)
    src_sel_q == acc_xfer_pkg::SRC_TIMER_CTRL_FOUR);

endmodule : acc_special_load

//--- rtl/acc_src_decode.sv
// Purpose: matches the opcode against the load group and picks the source nibble
// Assumes: inputs from logic on the same clock
// Notes: purely combinational
`timescale 1ns/10ps
`include "acc_xfer_map.svh"

module acc_src_decode (
  input wire logic instr_valid,
  input wire logic [9:0] opcode,
  input wire logic [3:0] adc_control_reg_three,
  input wire logic [2:0] stack_pointer,
  input wire logic [3:0] irq_control_reg_one,
  input wire logic [3:0] irq_control_reg_two,
  input wire logic [3:0] timer_control_reg_one,
  input wire logic [3:0] timer_control_reg_two,
  input wire logic [3:0] timer_control_reg_three,
  input wire logic [3:0] timer_control_reg_four,
  output logic hit,
  output acc_xfer_pkg::src_e sel,
  output acc_xfer_pkg::nibble_t data
);

  localparam acc_xfer_pkg::opcode_t OPS [`ACC_SOURCE_COUNT] = '{
    `ACC_OP_ADC_CTRL_THREE, `ACC_OP_STACK_POINTER, `ACC_OP_IRQ_CTRL_ONE, `ACC_OP_IRQ_CTRL_TWO,
    `ACC_OP_TIMER_CTRL_ONE, `ACC_OP_TIMER_CTRL_TWO, `ACC_OP_TIMER_CTRL_THREE, `ACC_OP_TIMER_CTRL_FOUR
  };

  acc_xfer_pkg::nibble_t srcs [`ACC_SOURCE_COUNT];
  logic [`ACC_SOURCE_COUNT-1:0] match;

  assign srcs[0] = adc_control_reg_three;
  assign srcs[1] = {`ACC_STACK_FILL, stack_pointer}; // [RL2]
  assign srcs[2] = irq_control_reg_one;
  assign srcs[3] = irq_control_reg_two;
  assign srcs[4] = timer_control_reg_one;
  assign srcs[5] = timer_control_reg_two;
  assign srcs[6] = timer_control_reg_three;
  assign srcs[7] = timer_control_reg_four;

  genvar i;
  generate
    for (i = 0; i < `ACC_SOURCE_COUNT; i++) begin : g_match
      assign match[i] = instr_valid && (opcode == OPS[i]); // [RL1] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8]
    end
  endgenerate

  always_comb begin
    hit = |match;
    sel = acc_xfer_pkg::SRC_NONE;
    data = `ACC_RESET;
    for (int k = 0; k < `ACC_SOURCE_COUNT; k++) begin
      if (match[k]) begin
        sel = acc_xfer_pkg::src_e'(4'(k + 1));
        data = srcs[k];
      end
    end
  end

endmodule : acc_src_decode

//--- test/tb.sv
// Purpose: self-checking bench for the accumulator load group
// Assumes: results show one edge after the instruction edge
// Notes: sources change every cycle so a late or early sample is seen
`timescale 1ns/10ps
`include "acc_xfer_map.svh"

module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [9:0] opcode = 10'h000;
  logic [3:0] srcs [8] = '{default: 4'h0};
  logic other_acc_write = 1'b0;
  logic [3:0] other_acc_data = 4'h0;
  logic [3:0] acc_q;
  logic load_done_q;
  acc_xfer_pkg::src_e src_sel_q;
  logic carry_write_q;
  logic skip_q;
  int failures = 0;
  int tests_run = 0;
  int seed = 96846;
  logic [3:0] exp_acc = 4'h0;
  logic [3:0] exp_sel = 4'h0;
  logic [9:0] ops [8] = '{`ACC_OP_ADC_CTRL_THREE, `ACC_OP_STACK_POINTER, `ACC_OP_IRQ_CTRL_ONE,
    `ACC_OP_IRQ_CTRL_TWO, `ACC_OP_TIMER_CTRL_ONE, `ACC_OP_TIMER_CTRL_TWO, `ACC_OP_TIMER_CTRL_THREE,
    `ACC_OP_TIMER_CTRL_FOUR};

  always #20 core_clk = ~core_clk;

  acc_special_load u_dut (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .opcode(opcode),
    .adc_control_reg_three(srcs[0]), .stack_pointer(srcs[1][2:0]),
    .irq_control_reg_one(srcs[2]), .irq_control_reg_two(srcs[3]),
    .timer_control_reg_one(srcs[4]), .timer_control_reg_two(srcs[5]),
    .timer_control_reg_three(srcs[6]), .timer_control_reg_four(srcs[7]),
    .other_acc_write(other_acc_write), .other_acc_data(other_acc_data),
    .acc_q(acc_q), .load_done_q(load_done_q), .src_sel_q(src_sel_q),
    .carry_write_q(carry_write_q), .skip_q(skip_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_all();
    chk(acc_q, exp_acc);
    chk(src_sel_q, exp_sel);
    chk({3'h0, load_done_q}, {3'h0, exp_sel != 4'h0});
    chk({2'h0, carry_write_q, skip_q}, 4'h0);
  endtask : chk_all

  // group member that a valid opcode selects, 8 when none
  function automatic int load_index(input logic v, input logic [9:0] op);
    load_index = 8;
    for (int k = 0; k < 8; k++) begin
      if (v && op === ops[k]) begin
        load_index = k;
      end
    end
  endfunction : load_index

  // drive one cycle, check the previous one, then work out what this one gives
  task automatic step(input logic v, input logic [9:0] op, input logic w, input logic [3:0] wd);
    int idx;
    @(posedge core_clk);
    instr_valid <= v;
    opcode <= op;
    other_acc_write <= w;
    other_acc_data <= wd;
    for (int k = 0; k < 8; k++) srcs[k] <= 4'($random(seed));
    #1;
    chk_all();
    idx = load_index(v, op);
    exp_sel = (idx < 8) ? 4'(idx + 1) : 4'h0;
    if (idx == 1) begin
      exp_acc = {1'b0, srcs[1][2:0]};
    end else if (idx < 8) begin
      exp_acc = srcs[idx];
    end else if (w) begin
      exp_acc = wd;
    end
  endtask : step

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    #1;
    exp_acc = 4'h0;
    exp_sel = 4'h0;
    chk_all();
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    $display("test reset done");
  endtask : do_reset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    chk_all();
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) step(1'b1, ops[i % 8], 1'b0, 4'h0);
    for (int i = 0; i < 8; i++) step(1'b1, ops[i], 1'b1, ~ops[i][3:0]);
    $display("test back to back loads done");
    step(1'b1, 10'h247, 1'b0, 4'h0);
    step(1'b1, 10'h053, 1'b1, 4'hA);
    step(1'b0, `ACC_OP_TIMER_CTRL_ONE, 1'b0, 4'h0);
    step(1'b1, 10'h3FF, 1'b0, 4'h0);
    for (int i = 0; i < 8; i++) step(1'b1, ops[i] ^ 10'h200, 1'b0, 4'h0);
    step(1'b0, 10'h000, 1'b0, 4'h0);
    $display("test refused opcodes done");
    do_reset();
    for (int i = 0; i < 300; i++) begin
      step(1'($random(seed)), ($random(seed) & 1) ? ops[$unsigned($random(seed)) % 8] : 10'($random(seed)),
        1'($random(seed)), 4'($random(seed)));
    end
    step(1'b0, 10'h000, 1'b0, 4'h0);
    $display("test random mix done");
    end_of_test();
  end

  initial begin
    #(40 * 2000);
    failures++;
    end_of_test();
  end
endmodule : tb
